// file: bus_matrix_pkg.sv
/*
  Constants for the multilayer bus matrix: master and slave indices,
  the system address map, bit-band geometry and bridge wait figures.
  Assumes a 32-bit byte address space and one core clock.
*/
package bus_matrix_pkg;
  // ----------------------------------------------------------------
  // Ports of the matrix
  // ----------------------------------------------------------------
  localparam int NM = 4;
  localparam int NS = 5;
  localparam int M_INSTRUCTION_CODE_PORT = 0;
  localparam int M_DATA_CODE_PORT = 1;
  localparam int M_SYS = 2;
  localparam int M_DMA = 3;
  localparam logic [2:0] S_FLASH = 3'h0;
  localparam logic [2:0] S_SRAM = 3'h1;
  localparam logic [2:0] S_CIPHER = 3'h2;
  localparam logic [2:0] S_APB = 3'h3;
  localparam logic [2:0] S_EBI = 3'h4;
  localparam logic [2:0] S_NONE = 3'h5;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] CODE_LAST = 32'h1fff_ffff;
  localparam logic [31:0] SYS_LAST = 32'hdfff_ffff;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h1000_0000;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_BB_BASE = 32'h2200_0000;
  localparam logic [31:0] PER_BASE = 32'h4000_0000;
  localparam logic [31:0] PER_BB_BASE = 32'h4200_0000;
  localparam logic [31:0] EBI_BASE = 32'h8000_0000;
  localparam logic [3:0] SEG_CODE = 4'h0;
  localparam logic [3:0] SEG_ALIAS = 4'h1;
  localparam logic [3:0] SEG_SRAM = 4'h2;
  localparam logic [3:0] SEG_PER = 4'h4;
  localparam logic [3:0] SEG_EBI = 4'h8;
  // Offset bits 27:25 that mark a bit-band alias inside a segment
  localparam logic [2:0] BAND_TAG = 3'h1;

  // ----------------------------------------------------------------
  // Peripheral windows, in 1 KB slots above the peripheral base
  // ----------------------------------------------------------------
  localparam logic [9:0] CIPHER_SLOT = 10'h380;
  localparam int NRUN = 23;
  localparam logic [9:0] RUN_START [NRUN] = '{
    10'h380, 10'h330, 10'h328, 10'h320, 10'h318, 10'h308, 10'h300,
    10'h228, 10'h220, 10'h218, 10'h210, 10'h208, 10'h200,
    10'h040, 10'h038, 10'h030, 10'h028, 10'h020, 10'h018,
    10'h010, 10'h008, 10'h004, 10'h000};
  localparam logic [9:0] RUN_LEN [NRUN] = '{
    10'h001, 10'h001, 10'h001, 10'h001, 10'h001, 10'h008, 10'h001,
    10'h001, 10'h001, 10'h003, 10'h002, 10'h001, 10'h001,
    10'h003, 10'h001, 10'h003, 10'h001, 10'h001, 10'h004,
    10'h001, 10'h001, 10'h002, 10'h001};

  // ----------------------------------------------------------------
  // Bridge wait cycles
  // ----------------------------------------------------------------
  localparam int BRIDGE_FIXED_WAIT = 2;
  localparam int SLAVE_WAIT = 1;
endpackage

// file: rr_arbiter.sv
/*
  Round-robin arbiter for one slave layer of the bus matrix.
  Assumes requests are levels and adv_i marks a cycle whose grant is used.
*/
`timescale 1ns/1ps
module rr_arbiter #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] req_i,
  input  wire logic         adv_i,
  output logic      [N-1:0] gnt_o
);
  logic [$clog2(N)-1:0] last_q;
  logic [$clog2(N)-1:0] win;

  // --------------------------------------------------------------
  // Search starts just after the last winner
  // --------------------------------------------------------------
  always_comb begin
    int i;
    i = 0;
    gnt_o = '0;
    win = last_q;
    for (int k = 1; k <= N; k++) begin
      i = (int'(last_q) + k) % N;
      if (gnt_o == '0 && req_i[i]) begin
        gnt_o[i] = 1'b1;
        win = i[$clog2(N)-1:0];
      end
    end
  end

  // Remember the winner
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= '0;
    end else if (adv_i && gnt_o != '0) begin
      last_q <= win;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  one_grant_a: assert property ($onehot0(gnt_o) && (gnt_o == '0 || (gnt_o & req_i) != '0))
    else $error("Arbiter grant is not a single requester");
  for (genvar g = 0; g < N; g++) begin : g_fair
    no_starve_a: assert property (gnt_o[g] && adv_i ##1 req_i[g] && $countones(req_i) > 1
                                  |-> !gnt_o[g])
      else $error("Arbiter granted the same master twice while others waited");
  end
endmodule // rr_arbiter

// file: bus_matrix_bitband_decoder.sv
/*
  Multilayer bus matrix with address decoder, code-space SRAM alias,
  bit-band conversion and a wait counter for the peripheral bridge.
  Assumes each master holds its request until its ready pulse, and each
  slave raises ready while its request stands once it has finished.
*/
`timescale 1ns/1ps
module bus_matrix_bitband_decoder #(
  parameter int RATIO_W = 4
) (
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_i,
  input  wire logic [bus_matrix_pkg::NM-1:0]             m_req_i,
  input  wire logic [bus_matrix_pkg::NM-1:0][31:0]       m_addr_i,
  input  wire logic [bus_matrix_pkg::NM-1:0]             m_write_i,
  input  wire logic [bus_matrix_pkg::NM-1:0][31:0]       m_wdata_i,
  output logic      [bus_matrix_pkg::NM-1:0]             m_ready_o,
  output logic      [bus_matrix_pkg::NM-1:0]             m_err_o,
  output logic      [bus_matrix_pkg::NM-1:0][31:0]       m_rdata_o,
  output logic      [bus_matrix_pkg::NS-1:0]             s_req_o,
  output logic      [bus_matrix_pkg::NS-1:0][31:0]       s_addr_o,
  output logic      [bus_matrix_pkg::NS-1:0]             s_write_o,
  output logic      [bus_matrix_pkg::NS-1:0][31:0]       s_wdata_o,
  output logic      [bus_matrix_pkg::NS-1:0][31:0]       s_wmask_o,
  input  wire logic [bus_matrix_pkg::NS-1:0][31:0]       s_rdata_i,
  input  wire logic [bus_matrix_pkg::NS-1:0]             s_ready_i,
  input  wire logic [RATIO_W-1:0]                        per_ratio_i
);
  localparam int NM = bus_matrix_pkg::NM;
  localparam int NS = bus_matrix_pkg::NS;
  localparam int WAIT_W = RATIO_W + 2;

  typedef enum logic {LAYER_IDLE, LAYER_BUSY} layer_e;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Slot falls inside a listed peripheral window
  function automatic logic per_mapped(input logic [9:0] slot);
    logic hit;
    hit = 1'b0;
    for (int r = 0; r < bus_matrix_pkg::NRUN; r++) begin
      if ((slot - bus_matrix_pkg::RUN_START[r]) < bus_matrix_pkg::RUN_LEN[r]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Address lies in the SRAM or peripheral bit-band alias
  function automatic logic bit_band(input logic [31:0] a);
    return (a[31:28] == bus_matrix_pkg::SEG_SRAM || a[31:28] == bus_matrix_pkg::SEG_PER)
           && a[27:25] == bus_matrix_pkg::BAND_TAG;
  endfunction

  // Address presented to the slave
  function automatic logic [31:0] phys(input logic [31:0] a);
    if (bit_band(a)) begin
      return {a[31:28], 8'h00, a[24:7], 2'b00};
    end else if (a[31:28] == bus_matrix_pkg::SEG_ALIAS) begin
      return {bus_matrix_pkg::SEG_SRAM, a[27:0]};
    end
    return a;
  endfunction

  // Slave selected by a master at an address
  function automatic logic [2:0] route(input int m, input logic [31:0] a);
    logic [2:0] s;
    logic [9:0] slot;
    logic       in_band;
    s = bus_matrix_pkg::S_NONE;
    in_band = a[27:20] == 8'h00 || a[27:25] == bus_matrix_pkg::BAND_TAG;
    slot = (a[27:25] == bus_matrix_pkg::BAND_TAG) ? a[24:15] : a[19:10];
    if (m == bus_matrix_pkg::M_INSTRUCTION_CODE_PORT || m == bus_matrix_pkg::M_DATA_CODE_PORT) begin
      if (a[31:28] == bus_matrix_pkg::SEG_CODE) begin
        s = bus_matrix_pkg::S_FLASH;
      end else if (a[31:20] == bus_matrix_pkg::SRAM_ALIAS_BASE[31:20]) begin
        s = bus_matrix_pkg::S_SRAM;
      end
    end else if (a <= bus_matrix_pkg::SYS_LAST) begin
      case (a[31:28])
        bus_matrix_pkg::SEG_CODE: begin
          if (m == bus_matrix_pkg::M_DMA) begin
            s = bus_matrix_pkg::S_FLASH;
          end
        end
        bus_matrix_pkg::SEG_SRAM: begin
          if (in_band) begin
            s = bus_matrix_pkg::S_SRAM;
          end
        end
        bus_matrix_pkg::SEG_PER: begin
          if (in_band && slot == bus_matrix_pkg::CIPHER_SLOT) begin
            s = bit_band(a) ? bus_matrix_pkg::S_NONE : bus_matrix_pkg::S_CIPHER;
          end else if (in_band && per_mapped(slot)) begin
            s = bus_matrix_pkg::S_APB;
          end
        end
        bus_matrix_pkg::SEG_EBI: begin
          s = bus_matrix_pkg::S_EBI;
        end
        default: begin
          s = bus_matrix_pkg::S_NONE;
        end
      endcase
    end
    return s;
  endfunction

  // Index of a one-hot master grant
  function automatic logic [1:0] oh_idx(input logic [NM-1:0] v);
    logic [1:0] i;
    i = 2'h0;
    for (int k = 0; k < NM; k++) begin
      if (v[k]) begin
        i = k[1:0];
      end
    end
    return i;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  layer_e                     lay_q  [NS];
  logic   [1:0]               own_q  [NS];
  logic   [WAIT_W-1:0]        wait_q [NS];
  logic   [NS-1:0]            bb_q;
  logic   [4:0]               bit_q  [NS];
  logic   [NM-1:0]            pend_q;
  logic   [NM-1:0][2:0]       dec;
  logic   [NM-1:0][31:0]      phy;
  logic   [NM-1:0]            isbb;
  logic   [NM-1:0]            take;
  logic   [NM-1:0]            err_now;
  logic   [NM-1:0]            granted;
  logic   [NS-1:0][NM-1:0]    want;
  logic   [NS-1:0][NM-1:0]    gnt;
  logic   [NS-1:0][1:0]       gsel;
  logic   [NS-1:0]            done;
  logic   [NM-1:0]            rsp_hit;
  logic   [NM-1:0][31:0]      rsp_data;
  logic   [RATIO_W-1:0]       eff_ratio;
  logic   [WAIT_W-1:0]        bridge_load;

  // ----------------------------------------------------------------
  // Per-master decode
  // ----------------------------------------------------------------
  for (genvar m = 0; m < NM; m++) begin : g_dec
    assign dec[m] = route(m, m_addr_i[m]);
    assign phy[m] = phys(m_addr_i[m]);
    assign isbb[m] = bit_band(m_addr_i[m]);
    assign take[m] = m_req_i[m] & ~pend_q[m] & ~m_ready_o[m];
    assign err_now[m] = take[m] & (dec[m] == bus_matrix_pkg::S_NONE);
  end

  // ----------------------------------------------------------------
  // One arbiter per slave layer
  // ----------------------------------------------------------------
  for (genvar s = 0; s < NS; s++) begin : g_layer
    for (genvar m = 0; m < NM; m++) begin : g_want
      assign want[s][m] = take[m] & (dec[m] == 3'(s)) & (lay_q[s] == LAYER_IDLE);
    end
    rr_arbiter #(.N(NM)) u_arb (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .req_i (want[s]),
      .adv_i (|want[s]),
      .gnt_o (gnt[s])
    );
    assign gsel[s] = oh_idx(gnt[s]);
    assign done[s] = (lay_q[s] == LAYER_BUSY) & s_ready_i[s] & (wait_q[s] == '0);
  end

  // Bridge wait: (fixed + slave cycles) times the clock ratio
  assign eff_ratio = (per_ratio_i == '0) ? RATIO_W'(1) : per_ratio_i;
  assign bridge_load = WAIT_W'(bus_matrix_pkg::BRIDGE_FIXED_WAIT + bus_matrix_pkg::SLAVE_WAIT)
                       * {2'b00, eff_ratio};

  // ----------------------------------------------------------------
  // Slave layers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < NS; s++) begin
      if (rst_i) begin
        lay_q[s] <= LAYER_IDLE;
        own_q[s] <= 2'h0;
        wait_q[s] <= '0;
        bb_q[s] <= 1'b0;
        bit_q[s] <= 5'h00;
        s_req_o[s] <= 1'b0;
        s_addr_o[s] <= 32'h0000_0000;
        s_write_o[s] <= 1'b0;
        s_wdata_o[s] <= 32'h0000_0000;
        s_wmask_o[s] <= 32'h0000_0000;
      end else if (gnt[s] != '0) begin
        lay_q[s] <= LAYER_BUSY;
        own_q[s] <= gsel[s];
        wait_q[s] <= (3'(s) == bus_matrix_pkg::S_APB) ? bridge_load : '0;
        bb_q[s] <= isbb[gsel[s]];
        bit_q[s] <= m_addr_i[gsel[s]][6:2];
        s_req_o[s] <= 1'b1;
        s_addr_o[s] <= phy[gsel[s]];
        s_write_o[s] <= m_write_i[gsel[s]];
        s_wdata_o[s] <= isbb[gsel[s]]
                        ? ({31'h0, m_wdata_i[gsel[s]][0]} << m_addr_i[gsel[s]][6:2])
                        : m_wdata_i[gsel[s]];
        s_wmask_o[s] <= isbb[gsel[s]] ? (32'h0000_0001 << m_addr_i[gsel[s]][6:2])
                                      : 32'hffff_ffff;
      end else if (done[s]) begin
        lay_q[s] <= LAYER_IDLE;
        s_req_o[s] <= 1'b0;
      end else if (wait_q[s] != '0) begin
        wait_q[s] <= wait_q[s] - WAIT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Responses back to the masters
  // ----------------------------------------------------------------
  always_comb begin
    rsp_hit = '0;
    rsp_data = '0;
    granted = '0;
    for (int s = 0; s < NS; s++) begin
      granted = granted | gnt[s];
      if (done[s]) begin
        rsp_hit[own_q[s]] = 1'b1;
        rsp_data[own_q[s]] = bb_q[s] ? {31'h0, s_rdata_i[s][bit_q[s]]}
                                     : s_rdata_i[s];
      end
    end
  end

  // Master status registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
      m_ready_o <= '0;
      m_err_o <= '0;
      m_rdata_o <= '0;
    end else begin
      pend_q <= (pend_q | granted) & ~rsp_hit;
      m_ready_o <= rsp_hit | err_now;
      m_err_o <= err_now;
      m_rdata_o <= rsp_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [WAIT_W-1:0] apb_cnt_q;
  logic [WAIT_W-1:0] apb_load_q;

  // Cycles since the bridge layer was granted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      apb_cnt_q <= '0;
      apb_load_q <= '0;
    end else if (gnt[bus_matrix_pkg::S_APB] != '0) begin
      apb_cnt_q <= '0;
      apb_load_q <= bridge_load;
    end else if (apb_cnt_q != '1) begin
      apb_cnt_q <= apb_cnt_q + WAIT_W'(1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  for (genvar m = 0; m < NM; m++) begin : g_chk
    reserved_err_a: assert property (err_now[m] |=> m_ready_o[m] && m_err_o[m])
      else $error("Reserved address did not answer with error");
    err_data_a: assert property (m_err_o[m] |-> m_ready_o[m] && m_rdata_o[m] == '0)
      else $error("Error response without ready or with data");
  end
  for (genvar s = 0; s < NS; s++) begin : g_grant
    free_grant_a: assert property (|want[s] |=> s_req_o[s] && lay_q[s] == LAYER_BUSY)
      else $error("Free layer did not start a transfer at once");
  end
  dma_alias_a: assert property (take[bus_matrix_pkg::M_DMA]
      && m_addr_i[bus_matrix_pkg::M_DMA][31:28] == bus_matrix_pkg::SEG_ALIAS
      |=> m_err_o[bus_matrix_pkg::M_DMA])
    else $error("DMA reached the code-space SRAM alias");
  instruction_code_port_range_a: assert property (take[bus_matrix_pkg::M_INSTRUCTION_CODE_PORT]
      && m_addr_i[bus_matrix_pkg::M_INSTRUCTION_CODE_PORT] > bus_matrix_pkg::CODE_LAST
      |=> m_err_o[bus_matrix_pkg::M_INSTRUCTION_CODE_PORT])
    else $error("Instruction port left the code region");
  cipher_band_a: assert property (take[bus_matrix_pkg::M_SYS] && isbb[bus_matrix_pkg::M_SYS]
      && phy[bus_matrix_pkg::M_SYS][31:28] == bus_matrix_pkg::SEG_PER
      && phy[bus_matrix_pkg::M_SYS][19:10] == bus_matrix_pkg::CIPHER_SLOT
      |=> m_err_o[bus_matrix_pkg::M_SYS])
    else $error("Bit-band access reached the cipher slave");
  band_mask_a: assert property (s_req_o[bus_matrix_pkg::S_SRAM] && bb_q[bus_matrix_pkg::S_SRAM]
      |-> $onehot(s_wmask_o[bus_matrix_pkg::S_SRAM]) && s_addr_o[bus_matrix_pkg::S_SRAM][1:0] == 2'b00)
    else $error("Bit-band access is not a single-bit word access");
  band_addr_a: assert property (gnt[bus_matrix_pkg::S_SRAM][bus_matrix_pkg::M_SYS]
      && isbb[bus_matrix_pkg::M_SYS]
      |=> s_addr_o[bus_matrix_pkg::S_SRAM] == {bus_matrix_pkg::SRAM_BASE[31:28], 8'h00,
          $past(m_addr_i[bus_matrix_pkg::M_SYS][24:7]), 2'b00})
    else $error("Bit-band target word address is wrong");
  bridge_wait_a: assert property (done[bus_matrix_pkg::S_APB]
      |-> apb_cnt_q >= apb_load_q && apb_load_q >= WAIT_W'(3))
    else $error("Bridge access finished before its wait cycles");

  // Bridge layer only ever carries peripheral addresses
  apb_seg_a: assert property (s_req_o[bus_matrix_pkg::S_APB]
      |-> s_addr_o[bus_matrix_pkg::S_APB][31:28] == bus_matrix_pkg::SEG_PER)
    else $error("Bridge layer carried a non-peripheral address");
  // Flash layer only ever carries code-segment addresses
  flash_seg_a: assert property (s_req_o[bus_matrix_pkg::S_FLASH]
      |-> s_addr_o[bus_matrix_pkg::S_FLASH][31:28] == bus_matrix_pkg::SEG_CODE)
    else $error("Flash layer carried an address outside the code segment");

  two_layers_c: cover property (s_req_o[bus_matrix_pkg::S_FLASH] && s_req_o[bus_matrix_pkg::S_SRAM]);
  band_done_c: cover property (done[bus_matrix_pkg::S_SRAM] && bb_q[bus_matrix_pkg::S_SRAM]);
  bridge_done_c: cover property (done[bus_matrix_pkg::S_APB] && per_ratio_i > RATIO_W'(1));
  error_c: cover property (|err_now);
endmodule // bus_matrix_bitband_decoder

// file: slave_bank.sv
/*
  Far-side model: five memory-like slaves answering after a set delay.
  Assumes the matrix holds each request until the cycle after ready.
*/
`timescale 1ns/1ps
module slave_bank (
  input  wire logic             clk_i,
  input  wire logic [4:0]       req_i,
  input  wire logic [4:0][31:0] addr_i,
  input  wire logic [4:0]       write_i,
  input  wire logic [4:0][31:0] wdata_i,
  input  wire logic [4:0][31:0] wmask_i,
  input  wire logic [3:0]       dly_i,
  output logic      [4:0][31:0] rdata_o,
  output logic      [4:0]       ready_o
);
  // ----
  // Storage, wait count and idle pattern
  // ----
  logic [31:0] mem [5][64];
  logic [3:0]  cnt [5];
  logic        tog;
  initial begin
    tog = 1'b0;
    for (int s = 0; s < 5; s++) begin
      cnt[s] = 4'h0;
      for (int i = 0; i < 64; i++) mem[s][i] = 32'h0;
    end
  end
  // Ready once the wait has run; unselected data changes every cycle
  always_comb begin
    for (int s = 0; s < 5; s++) begin
      ready_o[s] = req_i[s] && (cnt[s] >= dly_i);
      rdata_o[s] = ready_o[s] ? mem[s][addr_i[s][7:2]] : {16{tog, ~tog}};
    end
  end
  // Count wait cycles and commit masked writes
  always @(posedge clk_i) begin
    tog <= ~tog;
    for (int s = 0; s < 5; s++) begin
      cnt[s] <= !req_i[s] ? 4'h0 : (cnt[s] == 4'hf ? cnt[s] : cnt[s] + 4'h1);
      if (ready_o[s] && write_i[s]) begin
        mem[s][addr_i[s][7:2]] <= (mem[s][addr_i[s][7:2]] & ~wmask_i[s]) |
                                  (wdata_i[s] & wmask_i[s]);
      end
    end
  end
endmodule // slave_bank

// file: test_bus_matrix_bitband_decoder.sv
/*
  Self-checking bench for the bus matrix with bit-band decoding.
  Assumes the slave_bank model on the slave side and one 100 MHz clock.
*/
`timescale 1ns/1ps
module test_bus_matrix_bitband_decoder;
  // ----
  // Signals
  // ----
  logic              clk_i;
  logic              rst_i;
  logic [3:0]        m_req_i;
  logic [3:0][31:0]  m_addr_i;
  logic [3:0]        m_write_i;
  logic [3:0][31:0]  m_wdata_i;
  logic [3:0]        m_ready_o;
  logic [3:0]        m_err_o;
  logic [3:0][31:0]  m_rdata_o;
  logic [4:0]        s_req_o;
  logic [4:0][31:0]  s_addr_o;
  logic [4:0]        s_write_o;
  logic [4:0][31:0]  s_wdata_o;
  logic [4:0][31:0]  s_wmask_o;
  logic [4:0][31:0]  s_rdata_i;
  logic [4:0]        s_ready_i;
  logic [3:0]        per_ratio_i;
  logic [3:0]        dly;
  logic [31:0]       rd [4];
  logic [31:0]       sa [4];
  logic [31:0]       sm [4];
  logic [31:0]       sw [4];
  logic [4:0]        sl [4];
  logic              er [4];
  logic              swr [4];
  int                lat [4];
  int                num_errors = 0;
  int                tests_run = 0;

  bus_matrix_bitband_decoder #(.RATIO_W(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .m_req_i(m_req_i), .m_addr_i(m_addr_i), .m_write_i(m_write_i),
    .m_wdata_i(m_wdata_i), .m_ready_o(m_ready_o), .m_err_o(m_err_o),
    .m_rdata_o(m_rdata_o), .s_req_o(s_req_o), .s_addr_o(s_addr_o),
    .s_write_o(s_write_o), .s_wdata_o(s_wdata_o), .s_wmask_o(s_wmask_o),
    .s_rdata_i(s_rdata_i), .s_ready_i(s_ready_i), .per_ratio_i(per_ratio_i));
  slave_bank slaves (.clk_i(clk_i), .req_i(s_req_o), .addr_i(s_addr_o),
    .write_i(s_write_o), .wdata_i(s_wdata_o), .wmask_i(s_wmask_o), .dly_i(dly),
    .rdata_o(s_rdata_i), .ready_o(s_ready_i));

  // ----
  // Shared tasks
  // ----
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic tick();
    @(posedge clk_i) #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // One master transfer; records answer, latency and slave seen
  task automatic xfer(input int m, input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    sl[m] = 5'h0;
    tick();
    m_req_i[m] = 1'b1;
    m_addr_i[m] = a;
    m_write_i[m] = w;
    m_wdata_i[m] = d;
    while (m_ready_o[m] !== 1'b1 && n < 100) begin
      tick();
      n++;
      for (int s = 0; s < 5; s++) if (s_req_o[s] === 1'b1) begin
        sl[m][s] = 1'b1;
        sa[m] = s_addr_o[s];
        sm[m] = s_wmask_o[s];
        sw[m] = s_wdata_o[s];
        swr[m] = s_write_o[s];
      end
    end
    rd[m] = m_rdata_o[m];
    er[m] = m_err_o[m];
    lat[m] = n;
    chk(n < 100, "no answer");
    tick();
    m_req_i[m] = 1'b0;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_map();
    int          m [17] = '{0, 1, 0, 2, 2, 1, 3, 3, 3, 2, 2, 3, 2, 2, 2, 2, 2};
    logic [31:0] a [17] = '{32'h0000_0100, 32'h0000_0200, 32'h2000_0000, 32'h2000_0010,
      32'h0000_0000, 32'h1000_0040, 32'h1000_0040, 32'h8000_0000, 32'he000_0000,
      32'h400e_0000, 32'h400c_1000, 32'h400c_2000, 32'h4008_a000, 32'h4000_6c00,
      32'h4000_7000, 32'h43c0_0000, 32'h4008_0400};
    logic [2:0]  e [17] = '{3'h0, 3'h0, 3'h5, 3'h1, 3'h5, 3'h1, 3'h5, 3'h4, 3'h5,
      3'h2, 3'h5, 3'h3, 3'h3, 3'h3, 3'h5, 3'h5, 3'h5};
    logic [31:0] pa;
    int          x;
    for (int i = 0; i < 17; i++) begin
      xfer(m[i], a[i], 1'b0, 32'h0);
      pa = (a[i][31:28] == 4'h1) ? a[i] + 32'h1000_0000 : a[i];
      x = (e[i] == bus_matrix_pkg::S_NONE) ? 1 : (e[i] == bus_matrix_pkg::S_APB ? 5 : 2);
      chk(er[m[i]] === (e[i] == bus_matrix_pkg::S_NONE), "error flag");
      if (e[i] == bus_matrix_pkg::S_NONE) chk(rd[m[i]] === 32'h0, "error data");
      chk(lat[m[i]] == x, "latency");
      if (e[i] != bus_matrix_pkg::S_NONE) chk(sl[m[i]] === (5'h1 << e[i]) && sa[m[i]] === pa,
        "slave or address");
    end
    $display("map test done");
  endtask
  task automatic t_wait();
    int r [6] = '{0, 1, 2, 4, 1, 1};
    int d [6] = '{0, 0, 0, 0, 5, 3};
    int w;
    for (int i = 0; i < 6; i++) begin
      per_ratio_i = r[i][3:0];
      dly = d[i][3:0];
      xfer(2, (i == 5) ? 32'h2000_0000 : 32'h4000_0000, 1'b0, 32'h0);
      w = (i == 5) ? 0 : 3 * (r[i] > 1 ? r[i] : 1);
      chk(lat[2] == 2 + (w > d[i] ? w : d[i]), "bridge wait");
    end
    per_ratio_i = 4'h1;
    dly = 4'h0;
    $display("wait test done");
  endtask
  task automatic t_band();
    xfer(2, 32'h2000_0020, 1'b1, 32'hffff_0000);
    xfer(2, 32'h2200_040c, 1'b1, 32'h1);
    chk(sa[2] === 32'h2000_0020 && sm[2] === 32'h8 && sw[2][3] === 1'b1, "sram bit");
    chk(swr[2] === 1'b1, "write strobe");
    xfer(2, 32'h2000_0020, 1'b0, 32'h0);
    chk(rd[2] === 32'hffff_0008, "atomic merge");
    chk(swr[2] === 1'b0 && sm[2] === 32'hffff_ffff, "plain read");
    xfer(2, 32'h2200_0440, 1'b0, 32'h0);
    chk(rd[2] === 32'h1, "bit read set");
    xfer(2, 32'h2200_0400, 1'b0, 32'h0);
    chk(rd[2] === 32'h0, "bit read clear");
    xfer(2, 32'h420c_0014, 1'b1, 32'h0);
    chk(sa[2] === 32'h4000_6000 && sm[2] === 32'h20 && sw[2][5] === 1'b0, "periph bit");
    $display("bit-band test done");
  endtask
  task automatic t_par();
    fork
      xfer(0, 32'h0000_0010, 1'b0, 32'h0);
      xfer(2, 32'h2000_0030, 1'b0, 32'h0);
      xfer(3, 32'h8000_0010, 1'b0, 32'h0);
    join
    chk(lat[0] == 2 && lat[2] == 2 && lat[3] == 2, "parallel layers");
    fork
      xfer(1, 32'h1000_0000, 1'b0, 32'h0);
      xfer(2, 32'h2000_0000, 1'b0, 32'h0);
      xfer(3, 32'h2000_0004, 1'b0, 32'h0);
    join
    chk(lat[1] + lat[2] + lat[3] == 12 && lat[1] != lat[2] && lat[2] != lat[3]
        && lat[1] != lat[3], "shared slave turns");
    $display("parallel test done");
  endtask

  // ----
  // Run and verdict
  // ----
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    rst_i = 1'b1;
    m_req_i = '0;
    m_addr_i = '0;
    m_write_i = '0;
    m_wdata_i = '0;
    per_ratio_i = 4'h1;
    dly = 4'h0;
    repeat (20) tick();
    rst_i = 1'b0;
    chk(m_ready_o === 4'h0 && s_req_o === 5'h0, "idle after reset");
    t_map();
    t_wait();
    t_band();
    t_par();
    finish_test();
  end
endmodule // test_bus_matrix_bitband_decoder
